// ===== rtl/polseq_pkg.sv
// Package of constants for the point-of-load start-up and shutdown sequencer
package polseq_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] VCMD_OFS      = 8'h04;
    localparam logic [7:0] ON_DLY_OFS    = 8'h08;
    localparam logic [7:0] RISE_OFS      = 8'h0C;
    localparam logic [7:0] OFF_DLY_OFS   = 8'h10;
    localparam logic [7:0] FALL_OFS      = 8'h14;
    localparam logic [7:0] PG_DLY_OFS    = 8'h18;
    localparam logic [7:0] PG_TOL_OFS    = 8'h1C;
    localparam logic [7:0] HIZ_OFS       = 8'h20;
    localparam logic [7:0] STATUS_OFS    = 8'h24;
    localparam logic [7:0] VOUT_OFS      = 8'h28;
    localparam logic [7:0] STRAP_OFS     = 8'h2C;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int CTRL_RST_FACT  = 0;
    localparam int CTRL_RST_DEF   = 1;
    localparam int CTRL_RST_USER  = 2;
    localparam int CTRL_PG_POL    = 3;
    localparam int CTRL_HIZ_EN    = 4;
    localparam int CTRL_PG_DLY_EN = 5;
    localparam int CTRL_ERR_CLR   = 6;

    // ----------------------------------------
    // Voltages in millivolts, maximum as a percentage of the strap voltage
    // ----------------------------------------
    localparam logic [15:0] VSTRAP_LOW_MV  = 16'h0258;
    localparam logic [15:0] VSTRAP_OPEN_MV = 16'h04B0;
    localparam logic [15:0] VSTRAP_HIGH_MV = 16'h09C4;
    localparam int          VMAX_PCT       = 110;
    localparam logic [15:0] OVP_MV_RST     = 16'h1770;
    localparam logic [15:0] PG_TOL_RST     = 16'h0032;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ       = 200;
    localparam int LOAD_MS       = 10;
    localparam int PRE_RAMP_MS   = 5;
    localparam int LOAD_CYC      = LOAD_MS * 1000 * CLK_MHZ;
    localparam int PRE_RAMP_CYC  = PRE_RAMP_MS * 1000 * CLK_MHZ;
    localparam int US_CYC        = CLK_MHZ;
    localparam logic [15:0] RISE_US_RST = 16'h03E8;
    localparam logic [15:0] FALL_US_RST = 16'h03E8;
    localparam logic [15:0] HIZ_DLY_US  = 16'h0064;

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [10:0] {
        ST_FACT  = 11'h001,
        ST_STRAP = 11'h002,
        ST_DEF   = 11'h004,
        ST_USER  = 11'h008,
        ST_WAIT  = 11'h010,
        ST_IDLE  = 11'h020,
        ST_PRE   = 11'h040,
        ST_RISE  = 11'h080,
        ST_ON    = 11'h100,
        ST_OFFD  = 11'h200,
        ST_FALL  = 11'h400
    } polseq_state_t;

endpackage : polseq_pkg

// ===== rtl/polseq_top.sv
// Start-up and shutdown sequencer with AHB-Lite register slave
`timescale 1ns/1ps

module polseq_top
    import polseq_pkg::*;
#(
    parameter int LOAD_CYCLES = LOAD_CYC,
    parameter int PRE_CYCLES  = PRE_RAMP_CYC
)(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        enable_in,
    input  wire logic        enable_oe_in,
    input  wire logic        input_supply_good_in,
    input  wire logic        bus_address_strap_in,
    input  wire logic        sync_strap_in,
    input  wire logic [1:0]  output_voltage_strap_in,
    input  wire logic [15:0] vout_sense_mv_in,
    output logic      [15:0] vout_target_mv_out,
    output logic             output_drive_en_out,
    output logic             power_good_output_out,
    output logic             bus_address_out,
    output logic             ext_sync_sel_out,
    output logic             prebias_error_out,
    output logic             loading_out
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] en_sync;
    logic [2:0] pwr_sync;
    logic       en_level;
    logic       en_raw;
    logic       pwr_level;

    assign en_raw = enable_oe_in ? enable_in : 1'b1;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            en_sync  <= 3'h0;
            pwr_sync <= 3'h0;
        end
        else
        begin
            en_sync  <= {en_sync[1:0], en_raw};
            pwr_sync <= {pwr_sync[1:0], input_supply_good_in};
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            en_level  <= 1'b0;
            pwr_level <= 1'b0;
        end
        else
        begin
            if (en_sync[1] == en_sync[2])
                en_level <= en_sync[2];
            if (pwr_sync[1] == pwr_sync[2])
                pwr_level <= pwr_sync[2];
        end
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    logic        ph_wr;
    logic [7:0]  ph_addr;
    logic [15:0] vcmd;
    logic [15:0] on_dly_us;
    logic [15:0] rise_us;
    logic [15:0] off_dly_us;
    logic [15:0] fall_us;
    logic [15:0] pg_dly_us;
    logic [15:0] pg_tol_mv;
    logic [15:0] hiz_mv;
    logic        pg_pol;
    logic        hiz_en;
    logic        pg_dly_en;
    logic [15:0] vstrap_mv;
    logic [15:0] vmax_mv;
    logic        busy;
    logic        addr_ok;
    logic        do_wr;
    logic [2:0]  restore_req;
    logic        err_clr;
    polseq_state_t state;
    logic [15:0] vout_now;

    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign addr_ok = haddr_in[7:0] <= STRAP_OFS && haddr_in[1:0] == 2'h0
                     && haddr_in[31:8] == 24'h0;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ph_wr   <= 1'b0;
            ph_addr <= 8'h00;
        end
        else if (hready_in)
        begin
            ph_wr   <= hsel_in && htrans_in[1] && hwrite_in && addr_ok;
            ph_addr <= haddr_in[7:0];
        end
    end

    // Writes during loading are dropped, not stalled
    assign do_wr = ph_wr && !busy;
    assign restore_req = do_wr && ph_addr == CTRL_OFS ? hwdata_in[2:0] : 3'h0;
    assign err_clr = do_wr && ph_addr == CTRL_OFS && hwdata_in[CTRL_ERR_CLR];

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            hrdata_out <= 32'h0;
        else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in)
        begin
            unique case (haddr_in[7:0])
                CTRL_OFS:    hrdata_out <= {26'h0, pg_dly_en, hiz_en, pg_pol,
                                            3'h0};
                VCMD_OFS:    hrdata_out <= {16'h0, vcmd};
                ON_DLY_OFS:  hrdata_out <= {16'h0, on_dly_us};
                RISE_OFS:    hrdata_out <= {16'h0, rise_us};
                OFF_DLY_OFS: hrdata_out <= {16'h0, off_dly_us};
                FALL_OFS:    hrdata_out <= {16'h0, fall_us};
                PG_DLY_OFS:  hrdata_out <= {16'h0, pg_dly_us};
                PG_TOL_OFS:  hrdata_out <= {16'h0, pg_tol_mv};
                HIZ_OFS:     hrdata_out <= {16'h0, hiz_mv};
                STATUS_OFS:  hrdata_out <= {19'h0, prebias_error_out, busy,
                                            state};
                VOUT_OFS:    hrdata_out <= {16'h0, vout_now};
                STRAP_OFS:   hrdata_out <= {vmax_mv, 14'h0, ext_sync_sel_out,
                                            bus_address_out};
                default:     hrdata_out <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // Configuration sets and loading
    // ----------------------------------------
    logic [31:0] load_cnt;
    logic        pwr_prev;
    logic [15:0] vclamp;

    // Only the factory set reloads reset values; default and user sets only reload vcmd from the strap, so user set equals default set
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            vcmd <= 16'h0; on_dly_us <= 16'h0; rise_us <= RISE_US_RST;
            off_dly_us <= 16'h0; fall_us <= FALL_US_RST;
            pg_dly_us <= RISE_US_RST; pg_tol_mv <= PG_TOL_RST;
            hiz_mv <= 16'h0; pg_pol <= 1'b1; hiz_en <= 1'b0;
            pg_dly_en <= 1'b0;
        end
        else if (state == ST_FACT)
        begin
            on_dly_us <= 16'h0; rise_us <= RISE_US_RST;
            off_dly_us <= 16'h0; fall_us <= FALL_US_RST;
            pg_dly_us <= RISE_US_RST; pg_tol_mv <= PG_TOL_RST;
            hiz_mv <= 16'h0; pg_pol <= 1'b1; hiz_en <= 1'b0;
            pg_dly_en <= 1'b0;
        end
        else if (state == ST_STRAP || state == ST_DEF || state == ST_USER)
            vcmd <= vstrap_mv;
        else if (do_wr)
        begin
            unique case (ph_addr)
                CTRL_OFS:
                begin
                    pg_pol    <= hwdata_in[CTRL_PG_POL];
                    hiz_en    <= hwdata_in[CTRL_HIZ_EN];
                    pg_dly_en <= hwdata_in[CTRL_PG_DLY_EN];
                end
                VCMD_OFS:    vcmd <= hwdata_in[15:0] > vmax_mv ? vmax_mv
                                     : hwdata_in[15:0];
                ON_DLY_OFS:  on_dly_us  <= hwdata_in[15:0];
                RISE_OFS:    rise_us    <= hwdata_in[15:0];
                OFF_DLY_OFS: off_dly_us <= hwdata_in[15:0];
                FALL_OFS:    fall_us    <= hwdata_in[15:0];
                PG_DLY_OFS:  pg_dly_us  <= hwdata_in[15:0];
                PG_TOL_OFS:  pg_tol_mv  <= hwdata_in[15:0];
                HIZ_OFS:     hiz_mv     <= hwdata_in[15:0];
                default:     ;
            endcase
        end
    end

    // Strap capture; bus address only ever comes from here
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            bus_address_out  <= 1'b0;
            ext_sync_sel_out <= 1'b0;
            vstrap_mv        <= VSTRAP_OPEN_MV;
            vmax_mv          <= 16'h0;
        end
        else if (state == ST_STRAP)
        begin
            bus_address_out  <= bus_address_strap_in;
            ext_sync_sel_out <= sync_strap_in;
            unique case (output_voltage_strap_in)
                2'h0:    vstrap_mv <= VSTRAP_LOW_MV;
                2'h3:    vstrap_mv <= VSTRAP_HIGH_MV;
                default: vstrap_mv <= VSTRAP_OPEN_MV;
            endcase
        end
        // One cycle after capture so the limit sees the new strap value
        else if (state == ST_DEF)
            vmax_mv <= 16'((32'(vstrap_mv) * VMAX_PCT) / 100);
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic [31:0] tmr;
    logic [31:0] us_cnt;
    logic [15:0] ramp_start;
    logic        tmr_done;
    logic [31:0] ramp_len;
    logic [31:0] pg_cnt;
    logic        in_tol;
    logic signed [63:0] rise_step;

    assign busy = state inside {ST_FACT, ST_STRAP, ST_DEF, ST_USER, ST_WAIT};
    assign loading_out = busy;
    assign vclamp = vcmd > vmax_mv ? vmax_mv : vcmd;
    assign tmr_done = tmr == 32'h0;

    // Signed so a pre-bias above target ramps down instead of wrapping
    assign rise_step = ($signed(64'(vclamp)) - $signed(64'(ramp_start)))
                       * $signed(64'(ramp_len - tmr))
                       / $signed(64'(ramp_len | 32'h1));

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state      <= ST_FACT;
            tmr        <= 32'h0;
            load_cnt   <= 32'h0;
            pwr_prev   <= 1'b0;
            vout_now   <= 16'h0;
            ramp_start <= 16'h0;
            us_cnt     <= 32'h0;
            ramp_len   <= 32'h0;
            output_drive_en_out <= 1'b0;
        end
        else
        begin
            pwr_prev <= pwr_level;
            if (pwr_level && !pwr_prev)
            begin
                state    <= ST_FACT;
                load_cnt <= 32'(LOAD_CYCLES);
            end
            else if (restore_req[0])
            begin
                state <= ST_FACT; load_cnt <= 32'(LOAD_CYCLES);
            end
            else if (restore_req[1])
            begin
                state <= ST_STRAP; load_cnt <= 32'(LOAD_CYCLES);
            end
            else if (restore_req[2])
            begin
                state <= ST_STRAP; load_cnt <= 32'(LOAD_CYCLES);
            end
            else
            begin
                if (load_cnt != 32'h0)
                    load_cnt <= load_cnt - 32'h1;
                if (!tmr_done)
                    tmr <= tmr - 32'h1;
                unique case (state)
                    ST_FACT:  state <= ST_STRAP;
                    ST_STRAP: state <= ST_DEF;
                    ST_DEF:   state <= ST_USER;
                    ST_USER:  state <= ST_WAIT;
                    ST_WAIT:  if (load_cnt <= 32'h1) state <= ST_IDLE;
                    ST_IDLE:
                        if (en_level)
                        begin
                            state <= ST_PRE;
                            tmr <= 32'(PRE_CYCLES) + 32'(on_dly_us) * US_CYC;
                        end
                    ST_PRE:
                        if (!en_level)
                            state <= ST_IDLE;
                        else if (tmr_done)
                        begin
                            state      <= ST_RISE;
                            ramp_start <= vout_sense_mv_in;
                            vout_now   <= vout_sense_mv_in;
                            output_drive_en_out <= 1'b1;
                            ramp_len   <= 32'(rise_us) * US_CYC;
                            tmr        <= 32'(rise_us) * US_CYC;
                            us_cnt     <= 32'h0;
                        end
                    ST_RISE:
                    begin
                        // Linear interpolation, reaches target at expiry
                        vout_now <= tmr_done ? vclamp
                            : 16'($signed(64'(ramp_start)) + rise_step);
                        if (tmr_done) state <= ST_ON;
                    end
                    ST_ON:
                    begin
                        vout_now <= vclamp;
                        if (!en_level)
                        begin
                            state <= ST_OFFD;
                            tmr   <= 32'(off_dly_us) * US_CYC;
                        end
                    end
                    ST_OFFD:
                        if (tmr_done)
                        begin
                            state      <= ST_FALL;
                            ramp_start <= vout_now;
                            ramp_len   <= 32'(fall_us) * US_CYC;
                            tmr        <= 32'(fall_us) * US_CYC;
                            us_cnt     <= 32'(HIZ_DLY_US) * US_CYC;
                        end
                    ST_FALL:
                    begin
                        vout_now <= tmr_done ? 16'h0 : 16'((64'(ramp_start)
                            * 64'(tmr)) / 64'(ramp_len | 32'h1));
                        if (hiz_en && vout_now < hiz_mv)
                        begin
                            output_drive_en_out <= 1'b0;
                            state <= ST_IDLE;
                        end
                        else if (tmr_done)
                        begin
                            // Holds ground before releasing the output
                            if (us_cnt == 32'h0)
                            begin
                                output_drive_en_out <= 1'b0;
                                state <= ST_IDLE;
                            end
                            else
                                us_cnt <= us_cnt - 32'h1;
                        end
                    end
                    default: state <= ST_FACT;
                endcase
            end
        end
    end

    assign vout_target_mv_out = vout_now;

    // ----------------------------------------
    // Pre-bias error and power good
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            prebias_error_out <= 1'b0;
        else if (state == ST_PRE && tmr_done && vout_sense_mv_in > OVP_MV_RST)
            prebias_error_out <= 1'b1;
        else if (err_clr)
            prebias_error_out <= 1'b0;
    end

    // Widened so a large tolerance cannot wrap the window
    assign in_tol = 17'(vout_sense_mv_in) + 17'(pg_tol_mv) >= 17'(vclamp)
                    && 17'(vout_sense_mv_in) <= 17'(vclamp) + 17'(pg_tol_mv);

    logic pg_int;
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pg_cnt <= 32'h0;
            pg_int <= 1'b0;
        end
        else if (state != ST_ON || !in_tol || prebias_error_out)
        begin
            pg_int <= 1'b0;
            pg_cnt <= 32'(pg_dly_en ? pg_dly_us : rise_us) * US_CYC;
        end
        else if (pg_cnt == 32'h0)
            pg_int <= 1'b1;
        else
            pg_cnt <= pg_cnt - 32'h1;
    end

    assign power_good_output_out = pg_int ~^ pg_pol;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking chk_cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    pg_quiet_a: assert property (
        state != ST_ON |=> !pg_int) else $error("pg while not on");
    pg_fault_a: assert property (
        pg_int |-> !prebias_error_out) else $error("pg with fault");
    busy_wr_a: assert property (
        state == ST_WAIT |=> $stable(vcmd) && $stable(rise_us))
        else $error("setting changed while loading");
    vmax_clamp_a: assert property (
        state == ST_ON |-> vout_now <= vmax_mv) else $error("over max");
    load_order_a: assert property (
        state == ST_FACT && !restore_req[0] && !(pwr_level && !pwr_prev)
        |=> state == ST_STRAP ##1 state == ST_DEF ##1 state == ST_USER)
        else $error("load order");
    pre_en_a: assert property (
        state == ST_IDLE && !busy && en_level && restore_req == 3'h0
        && !(pwr_level && !pwr_prev) |=> state == ST_PRE)
        else $error("enable missed");
    drive_a: assert property (
        state == ST_IDLE |=> !output_drive_en_out || state == ST_PRE)
        else $error("drive in idle");
    stop_a: assert property (
        state == ST_ON && !en_level && restore_req == 3'h0
        && !(pwr_level && !pwr_prev) |=> state == ST_OFFD)
        else $error("stop missed");
    on_c: cover property (state == ST_ON && pg_int);
    off_c: cover property (state == ST_FALL ##1 state == ST_IDLE);
    rst_c: cover property (restore_req[1]);

endmodule : polseq_top

// ===== testbench/polseq_plant.sv
// Output plant and load model on the far side of the sequencer
`timescale 1ns/1ps
module polseq_plant (
    input  wire logic        clk_in,
    input  wire logic        drive_en_in,
    input  wire logic [15:0] target_mv_in,
    input  wire logic [15:0] bias_mv_in,
    output logic      [15:0] sense_mv_out
);
    // ----------------------------------------
    // Output node
    // ----------------------------------------
    // Floating output goes to the bias level on the next clock, never holds last target
    always_ff @(posedge clk_in)
    begin
        sense_mv_out <= drive_en_in ? target_mv_in : bias_mv_in;
    end
endmodule : polseq_plant

// ===== testbench/test_polseq_top.sv
// Self-checking bench of the point-of-load sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_polseq_top;
    import polseq_pkg::*;
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0, hready, hresp;
    logic        en = 1'b0, en_oe = 1'b1, sup = 1'b0, drv, pg;
    logic        addr_o, sync_o, err, loading;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [15:0] bias = 16'h0000, sense, target;
    int          bad_count = 0, comparisons = 0, cyc = 0, n;
    always #2.5 clk_in = ~clk_in;
    polseq_top #(.LOAD_CYCLES(50), .PRE_CYCLES(20)) i_polseq_top (
        .clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .enable_in(en), .enable_oe_in(en_oe), .input_supply_good_in(sup),
        .bus_address_strap_in(1'b1), .sync_strap_in(1'b1),
        .output_voltage_strap_in(2'h3), .vout_sense_mv_in(sense),
        .vout_target_mv_out(target), .output_drive_en_out(drv),
        .power_good_output_out(pg), .bus_address_out(addr_o),
        .ext_sync_sel_out(sync_o), .prebias_error_out(err),
        .loading_out(loading));
    polseq_plant i_polseq_plant (.clk_in(clk_in), .drive_en_in(drv),
        .target_mv_in(target), .bias_mv_in(bias), .sense_mv_out(sense));
    // ----------------------------------------
    // Bus and verdict
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, a};
        @(posedge clk_in); while (hready !== 1'b1) @(posedge clk_in);
        htrans <= 2'h0; hwdata <= d;
        @(posedge clk_in); while (hready !== 1'b1) @(posedge clk_in);
        rd = hrdata;
    endtask : bus
    task automatic results;
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            bad_count++;
            results;
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic load_test;
        `CHK(loading, 1'b1)
        bus(1'b1, VCMD_OFS, 32'h0000_0400);
        for (n = 0; n < 500 && loading !== 1'b0; n++) @(posedge clk_in);
        bus(1'b0, VCMD_OFS, 32'h0);
        `CHK(rd[15:0], VSTRAP_HIGH_MV)
        `CHK({addr_o, sync_o}, 2'h3)
    endtask : load_test
    task automatic clamp_test;
        bus(1'b1, VCMD_OFS, 32'h0000_FFFF);
        bus(1'b0, VCMD_OFS, 32'h0);
        `CHK(rd[15:0], 16'h0ABE)
    endtask : clamp_test
    task automatic start_test;
        bus(1'b1, VCMD_OFS, 32'h0000_07D0);
        bus(1'b1, ON_DLY_OFS, 32'h0);
        // Short ramps keep the run small, below host advice
        bus(1'b1, RISE_OFS, 32'h1);
        bus(1'b1, OFF_DLY_OFS, 32'h0);
        bus(1'b1, FALL_OFS, 32'h1);
        en_oe <= 1'b0; // Undriven pin reads as asserted
        for (n = 0; n < 3000 && pg !== 1'b1; n++) @(posedge clk_in);
        `CHK(n >= 400, 1'b1)
        `CHK(target, 16'h07D0)
    endtask : start_test
    task automatic stop_test;
        en_oe <= 1'b1;
        for (n = 0; n < 30000 && drv !== 1'b0; n++) @(posedge clk_in);
        `CHK(n >= 20200, 1'b1)
        `CHK({target, pg}, 17'h0)
    endtask : stop_test
    task automatic bias_test;
        bias <= 16'h1B58;
        en <= 1'b1;
        for (n = 0; n < 2000 && err !== 1'b1; n++) @(posedge clk_in);
        `CHK(err, 1'b1)
        `CHK(target, 16'h1B58)
        bus(1'b1, CTRL_OFS, 32'h0000_0048);
        @(posedge clk_in);
        `CHK(err, 1'b0)
    endtask : bias_test
    task automatic restore_test;
        // Restore default set, power good polarity low
        bus(1'b1, CTRL_OFS, 32'h0000_0002);
        @(posedge clk_in);
        `CHK(loading, 1'b1)
        `CHK(pg, 1'b1)
        for (n = 0; n < 500 && loading !== 1'b0; n++) @(posedge clk_in);
        bus(1'b0, VCMD_OFS, 32'h0);
        `CHK(rd[15:0], VSTRAP_HIGH_MV)
        bus(1'b1, CTRL_OFS, 32'h0000_0008);
    endtask : restore_test
    initial
    begin
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        sup <= 1'b1;
        repeat (10) @(posedge clk_in);
        load_test;
        clamp_test;
        start_test;
        stop_test;
        restore_test;
        bias_test;
        results;
    end
endmodule : test_polseq_top
